// ==== design/pci_config_access_mechanism.sv ====
// Host bridge configuration address/data port logic with I/O forwarding
//
// Summary of operation
// [R1] A 32-bit target-select register answers at I/O port 0cf8h.
// [R2] A 32-bit data window at I/O port 0cfch reads or writes the selected config register.
// [R3] Software loads the target select first; a later data window access moves the data.
// [R4] Data window accesses pass the host byte enables so only enabled bytes are touched.
// [R5] Only full dword accesses to 0cf8h hit the register; narrower ones go out as plain I/O.
// [R6] The bus number comes from target-select bits 23 to 16.
// [R7] The device number, five bits, comes from target-select bits 15 to 11.
// [R8] The function number comes from target-select bits 10 to 8.
// [R9] The dword register index comes from target-select bits 7 to 2.
// [R10] A local config cycle raises exactly one AD line between AD31 and AD11 as IDSEL.
// [R11] Device n selects AD(11+n), device 0 being the host bridge and device 20 AD31.
// [R12] Only the bootstrap processor should use the ports, never two processors at once.
// [R13] A data window access makes a config cycle only with bit 31 set, else plain I/O.
`timescale 1ns/1ps
`default_nettype none
module pci_config_access_mechanism
    import pci_cfg_pkg::*;
#(
    parameter logic [7:0] PRIMARY_BUS = 8'h00
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    // Processor-bus I/O cycle
    input  wire logic        i_io_req,
    input  wire logic        i_io_write,
    input  wire logic [15:0] i_io_addr,
    input  wire logic [3:0]  i_io_be,
    input  wire logic [31:0] i_io_wdata,
    output logic             o_io_ack,
    output logic [31:0]      o_io_rdata,
    // Ordinary I/O forwarded toward PCI/ISA
    output logic             o_fwd_req,
    output logic             o_fwd_write,
    output logic [15:0]      o_fwd_addr,
    output logic [3:0]       o_fwd_be,
    output logic [31:0]      o_fwd_wdata,
    input  wire logic        i_fwd_done,
    input  wire logic [31:0] i_fwd_rdata,
    // Configuration cycle toward PCI
    output logic             o_pci_req,
    output logic             o_pci_type1,
    output logic [31:0]      o_pci_addr,
    output logic [3:0]       o_pci_be,
    output logic             o_pci_write,
    output logic [31:0]      o_pci_wdata,
    input  wire logic        i_pci_done,
    input  wire logic        i_pci_abort,
    input  wire logic [31:0] i_pci_rdata,
    // Current target select, for observation
    output logic [31:0]      o_target_select
);
    function automatic logic same_dword(input logic [15:0] a, input logic [15:0] b);
        same_dword = (a[15:2] == b[15:2]);
    endfunction

    bridge_state_e state;
    bridge_state_e next_state;

    logic [31:0] cfg_target_select;
    logic        hit_select;
    logic        hit_window;
    logic        full_dword;
    logic        take;
    logic        select_access;
    logic        window_access;
    logic        cfg_start;
    logic        cfg_done;
    logic [31:0] cfg_rdata;

    // Requests while busy are ignored; one host cycle is outstanding at a time
    assign take       = i_io_req && (state == ST_IDLE);
    assign full_dword = (i_io_be == BE_FULL_DWORD);

    always_comb begin
        hit_select = 1'b0;
        hit_window = 1'b0;
        if (same_dword(i_io_addr, IO_PORT_TARGET_SELECT)) begin
            hit_select = 1'b1; // [R1]
        end else if (same_dword(i_io_addr, IO_PORT_DATA_WINDOW)) begin
            hit_window = 1'b1; // [R2]
        end
    end

    // Narrow select-port cycles are not ours; they go out untouched
    assign select_access = hit_select && full_dword; // [R5]
    assign window_access = hit_window && cfg_target_select[ENABLE_BIT]; // [R13]
    assign cfg_start     = take && window_access; // [R3]

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (take && window_access) begin
                    next_state = ST_CFG;
                end else if (take && !select_access) begin
                    next_state = ST_FWD;
                end
            end
            ST_FWD: begin
                if (i_fwd_done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_CFG: begin
                if (cfg_done) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Target select register; reserved bits stay zero
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_target_select <= TARGET_SELECT_RESET;
        end else if (take && select_access && i_io_write) begin
            cfg_target_select <= i_io_wdata & TARGET_SELECT_WMASK; // [R1] [R5]
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_target_select <= TARGET_SELECT_RESET;
        end else if (take && select_access && i_io_write) begin
            o_target_select <= i_io_wdata & TARGET_SELECT_WMASK;
        end
    end

    // Forwarded ordinary I/O, held until the far side completes
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_fwd_req   <= 1'b0;
            o_fwd_write <= 1'b0;
            o_fwd_addr  <= 16'h0000;
            o_fwd_be    <= 4'h0;
            o_fwd_wdata <= 32'h0000_0000;
        end else if (take && !select_access && !window_access) begin
            o_fwd_req   <= 1'b1; // [R5] [R13]
            o_fwd_write <= i_io_write;
            o_fwd_addr  <= i_io_addr;
            o_fwd_be    <= i_io_be;
            o_fwd_wdata <= i_io_wdata;
        end else if (o_fwd_req && i_fwd_done) begin
            o_fwd_req   <= 1'b0;
        end
    end

    // Completion toward the host, one pulse per taken cycle
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_io_ack   <= 1'b0;
            o_io_rdata <= 32'h0000_0000;
        end else if (take && select_access) begin
            o_io_ack   <= 1'b1;
            o_io_rdata <= cfg_target_select;
        end else if (state == ST_FWD && i_fwd_done) begin
            o_io_ack   <= 1'b1;
            o_io_rdata <= i_fwd_rdata;
        end else if (state == ST_CFG && cfg_done) begin
            o_io_ack   <= 1'b1;
            o_io_rdata <= cfg_rdata; // [R2] [R3]
        end else begin
            o_io_ack   <= 1'b0;
        end
    end

    // Field split of the target select drives the cycle builder
    cfg_cycle_engine #(
        .PRIMARY_BUS (PRIMARY_BUS)
    ) u_cycle (
        .i_sys_clk   (i_sys_clk),
        .i_rst_n     (i_rst_n),
        .i_start     (cfg_start),
        .i_write     (i_io_write),
        .i_be        (i_io_be),
        .i_wdata     (i_io_wdata),
        .i_bus       (cfg_target_select[BUS_MSB:BUS_LSB]),
        .i_dev       (cfg_target_select[DEV_MSB:DEV_LSB]),
        .i_func      (cfg_target_select[FUNC_MSB:FUNC_LSB]),
        .i_reg       (cfg_target_select[REG_MSB:REG_LSB]),
        .o_done      (cfg_done),
        .o_rdata     (cfg_rdata),
        .o_pci_req   (o_pci_req),
        .o_pci_type1 (o_pci_type1),
        .o_pci_addr  (o_pci_addr),
        .o_pci_be    (o_pci_be),
        .o_pci_write (o_pci_write),
        .o_pci_wdata (o_pci_wdata),
        .i_pci_done  (i_pci_done),
        .i_pci_abort (i_pci_abort),
        .i_pci_rdata (i_pci_rdata)
    );
endmodule
`default_nettype wire

// ==== design/pci_cfg_pkg.sv ====
// Constants for the configuration address/data port bridge
package pci_cfg_pkg;
    localparam logic [15:0] IO_PORT_TARGET_SELECT = 16'h0cf8;
    localparam logic [15:0] IO_PORT_DATA_WINDOW   = 16'h0cfc;
    localparam logic [31:0] TARGET_SELECT_RESET   = 32'h0000_0000;
    localparam logic [31:0] TARGET_SELECT_WMASK   = 32'h80ff_fffc;
    localparam logic [3:0]  BE_FULL_DWORD         = 4'hf;
    localparam logic [3:0]  BE_NONE               = 4'h0;
    localparam int          ENABLE_BIT            = 31;
    localparam int          BUS_MSB               = 23;
    localparam int          BUS_LSB               = 16;
    localparam int          DEV_MSB               = 15;
    localparam int          DEV_LSB               = 11;
    localparam int          FUNC_MSB              = 10;
    localparam int          FUNC_LSB              = 8;
    localparam int          REG_MSB               = 7;
    localparam int          REG_LSB               = 2;
    localparam int          IDSEL_BASE            = 11;
    localparam logic [4:0]  DEV_MAX_IDSEL         = 5'h14;
    localparam logic [1:0]  ADDR_TYPE0            = 2'h0;
    localparam logic [1:0]  ADDR_TYPE1            = 2'h1;
    localparam logic [31:0] ABORT_READ_DATA       = 32'hffff_ffff;
    localparam logic [31:0] NO_BYTE_READ_DATA     = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FWD  = 2'b01,
        ST_CFG  = 2'b10
    } bridge_state_e;
endpackage

// ==== design/cfg_cycle_engine.sv ====
// Builds and runs one configuration cycle toward the PCI side
`timescale 1ns/1ps
`default_nettype none
module cfg_cycle_engine
    import pci_cfg_pkg::*;
#(
    parameter logic [7:0] PRIMARY_BUS = 8'h00
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_start,
    input  wire logic        i_write,
    input  wire logic [3:0]  i_be,
    input  wire logic [31:0] i_wdata,
    input  wire logic [7:0]  i_bus,
    input  wire logic [4:0]  i_dev,
    input  wire logic [2:0]  i_func,
    input  wire logic [5:0]  i_reg,
    output logic             o_done,
    output logic [31:0]      o_rdata,
    output logic             o_pci_req,
    output logic             o_pci_type1,
    output logic [31:0]      o_pci_addr,
    output logic [3:0]       o_pci_be,
    output logic             o_pci_write,
    output logic [31:0]      o_pci_wdata,
    input  wire logic        i_pci_done,
    input  wire logic        i_pci_abort,
    input  wire logic [31:0] i_pci_rdata
);
    // One IDSEL line in AD[31:11], device n on AD(11+n)
    function automatic logic [31:0] idsel_of(input logic [4:0] dev);
        idsel_of = 32'h0000_0001 << (IDSEL_BASE + int'(dev)); // [R10] [R11]
    endfunction

    logic local_bus;
    logic no_target;
    logic no_bytes;

    assign local_bus = (i_bus == PRIMARY_BUS);
    // Devices above the last IDSEL line have no select; treated as absent
    assign no_target = local_bus && (i_dev > DEV_MAX_IDSEL);
    assign no_bytes  = (i_be == BE_NONE);

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pci_req   <= 1'b0;
            o_pci_type1 <= 1'b0;
            o_pci_addr  <= 32'h0000_0000;
            o_pci_be    <= 4'h0;
            o_pci_write <= 1'b0;
            o_pci_wdata <= 32'h0000_0000;
        end else if (i_start && !o_pci_req && !no_target && !no_bytes) begin
            o_pci_req   <= 1'b1;
            o_pci_type1 <= !local_bus;
            o_pci_be    <= i_be; // [R4]
            o_pci_write <= i_write;
            o_pci_wdata <= i_wdata;
            if (local_bus) begin
                o_pci_addr <= idsel_of(i_dev) | {21'h0, i_func, i_reg, ADDR_TYPE0}; // [R8] [R9]
            end else begin
                o_pci_addr <= {8'h00, i_bus, i_dev, i_func, i_reg, ADDR_TYPE1}; // [R6] [R7]
            end
        end else if (o_pci_req && (i_pci_done || i_pci_abort)) begin
            o_pci_req <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_done  <= 1'b0;
            o_rdata <= 32'h0000_0000;
        end else if (i_start && !o_pci_req && no_bytes) begin
            // No byte enabled: the register is not touched
            o_done  <= 1'b1;
            o_rdata <= NO_BYTE_READ_DATA; // [R4]
        end else if (i_start && !o_pci_req && no_target) begin
            o_done  <= 1'b1;
            o_rdata <= ABORT_READ_DATA;
        end else if (o_pci_req && i_pci_abort) begin
            o_done  <= 1'b1;
            o_rdata <= ABORT_READ_DATA;
        end else if (o_pci_req && i_pci_done) begin
            o_done  <= 1'b1;
            o_rdata <= i_pci_rdata;
        end else begin
            o_done  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== test/cfg_bridge_props.sv ====
// Assertion checker for the configuration port bridge
`timescale 1ns/1ps
`default_nettype none
module cfg_bridge_props
    import pci_cfg_pkg::*;
#(
    parameter logic [7:0] PRIMARY_BUS = 8'h00
) (
    input wire logic        i_sys_clk,
    input wire logic        i_rst_n,
    input wire logic        i_io_req,
    input wire logic        i_io_write,
    input wire logic [15:0] i_io_addr,
    input wire logic [3:0]  i_io_be,
    input wire logic [31:0] i_io_wdata,
    input wire logic        o_io_ack,
    input wire logic [31:0] o_io_rdata,
    input wire logic        o_fwd_req,
    input wire logic        o_pci_req,
    input wire logic        o_pci_type1,
    input wire logic        o_pci_write,
    input wire logic [31:0] o_pci_addr,
    input wire logic [3:0]  o_pci_be,
    input wire logic        i_pci_done,
    input wire logic [31:0] i_pci_rdata,
    input wire logic [31:0] o_target_select
);
    logic        busy;
    logic        take;
    logic        sel;
    logic        dat;
    logic        hit;
    logic [31:0] ts;
    assign ts   = o_target_select;
    // A request in the ack cycle is taken as well
    assign take = i_io_req & (~busy | o_io_ack);
    assign sel  = take & (i_io_addr[15:2] == IO_PORT_TARGET_SELECT[15:2]);
    assign dat  = take & (i_io_addr[15:2] == IO_PORT_DATA_WINDOW[15:2]);
    assign hit  = dat & ts[31] & (i_io_be != BE_NONE)
                & ((ts[23:16] != PRIMARY_BUS) | (ts[15:11] <= DEV_MAX_IDSEL));
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy <= 1'b0;
        end else begin
            busy <= take | (busy & ~o_io_ack);
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    AST_SEL_WR: assert property (
        sel & i_io_write & (i_io_be == BE_FULL_DWORD) |=> o_io_ack
        && ts == ($past(i_io_wdata) & TARGET_SELECT_WMASK)) else $error("select write lost");
    AST_SEL_RD: assert property (
        sel & ~i_io_write & (i_io_be == BE_FULL_DWORD) |=> o_io_ack && o_io_rdata == $past(ts))
        else $error("select read wrong");
    AST_NARROW: assert property (
        sel & (i_io_be != BE_FULL_DWORD) |=> o_fwd_req && $stable(ts))
        else $error("narrow select not forwarded");
    AST_OFF: assert property (
        dat & ~ts[31] |=> o_fwd_req && !o_pci_req) else $error("disabled window not forwarded");
    AST_T0: assert property (
        $rose(o_pci_req) && !o_pci_type1 |-> o_pci_addr == {21'h1 << ts[15:11], ts[10:2], 2'b00})
        else $error("type 0 address wrong");
    AST_T1: assert property (
        $rose(o_pci_req) && o_pci_type1 |-> o_pci_addr == {8'h00, ts[23:2], 2'b01}
        && ts[23:16] != PRIMARY_BUS) else $error("type 1 address wrong");
    AST_BE: assert property (
        hit |=> o_pci_req && o_pci_be == $past(i_io_be)) else $error("byte enables wrong");
    AST_NOBYTE: assert property (
        dat & ts[31] & (i_io_be == BE_NONE) |=> !o_pci_req ##1 o_io_ack
        && o_io_rdata == NO_BYTE_READ_DATA) else $error("empty byte enable not refused");
    AST_DONE: assert property (
        o_pci_req && i_pci_done && !o_pci_write |=> !o_pci_req ##1 o_io_ack
        && o_io_rdata == $past(i_pci_rdata, 2)) else $error("config read data wrong");
    cover property (sel & i_io_write);
    cover property ($rose(o_pci_req) && o_pci_type1);
    cover property (o_fwd_req ##1 !o_fwd_req);
endmodule
bind pci_config_access_mechanism cfg_bridge_props #(.PRIMARY_BUS(PRIMARY_BUS)) u_props (.*);
`default_nettype wire

// ==== test/cfg_far_model.sv ====
// Far side model: forwarded I/O target and one configuration dword
`timescale 1ns/1ps
`default_nettype none
module cfg_far_model #(
    parameter logic [31:0] FWD_WORD = 32'h1357_9bdf
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    input  wire logic [3:0]  i_wait,
    input  wire logic        i_abort_en,
    input  wire logic        i_fwd_req,
    input  wire logic        i_pci_req,
    input  wire logic        i_pci_write,
    input  wire logic [3:0]  i_pci_be,
    input  wire logic [31:0] i_pci_wdata,
    output logic             o_fwd_done,
    output logic [31:0]      o_fwd_rdata,
    output logic             o_pci_done,
    output logic             o_pci_abort,
    output logic [31:0]      o_pci_rdata
);
    logic [3:0]  cnt;
    logic        fin;
    logic [31:0] word;
    logic [31:0] m;
    assign m = {{8{i_pci_be[3]}}, {8{i_pci_be[2]}}, {8{i_pci_be[1]}}, {8{i_pci_be[0]}}};
    // Data lines show the inverse outside the answer cycle
    assign o_fwd_rdata = o_fwd_done ? FWD_WORD : ~FWD_WORD;
    assign o_pci_rdata = o_pci_done ? word : ~word;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {cnt, fin, word, o_fwd_done, o_pci_done, o_pci_abort} <= '0;
        end else begin
            {o_fwd_done, o_pci_done, o_pci_abort} <= 3'b000;
            if (o_fwd_done | o_pci_done | o_pci_abort) begin
                fin <= 1'b1;
            end else if (!(i_fwd_req | i_pci_req)) begin
                {fin, cnt} <= '0;
            end else if (!fin && cnt == i_wait) begin
                o_fwd_done  <= i_fwd_req;
                o_pci_done  <= i_pci_req & ~i_abort_en;
                o_pci_abort <= i_pci_req & i_abort_en;
                if (i_pci_req & i_pci_write & ~i_abort_en) begin
                    word <= (word & ~m) | (i_pci_wdata & m);
                end
            end else if (!fin) begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for the configuration port bridge
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pci_cfg_pkg::*;
    logic        i_sys_clk, i_rst_n, i_io_req, i_io_write, o_io_ack, o_fwd_req, o_fwd_write;
    logic        i_fwd_done, o_pci_req, o_pci_type1, o_pci_write, i_pci_done, i_pci_abort;
    logic        abort_en, seen;
    logic [15:0] i_io_addr, o_fwd_addr, cap_fwd;
    logic [3:0]  i_io_be, o_fwd_be, o_pci_be, wait_n;
    logic [31:0] i_io_wdata, o_io_rdata, o_fwd_wdata, i_fwd_rdata, o_pci_addr, o_pci_wdata;
    logic [31:0] i_pci_rdata, o_target_select, exp_w, cap_addr, sel, d, m, cap_fwdat;
    logic [4:0]  cap_fctl;
    logic [4:0]  devs [4] = '{5'h00, 5'h01, 5'h09, 5'h14};
    logic [3:0]  bes [4]  = '{4'hf, 4'h5, 4'ha, 4'h8};
    int          failures, n_checks, npci, n0;
    pci_config_access_mechanism u_pci_config_access_mechanism (.*);
    cfg_far_model u_cfg_far_model (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_wait(wait_n),
        .i_abort_en(abort_en), .i_fwd_req(o_fwd_req), .i_pci_req(o_pci_req),
        .i_pci_write(o_pci_write), .i_pci_be(o_pci_be), .i_pci_wdata(o_pci_wdata),
        .o_fwd_done(i_fwd_done), .o_fwd_rdata(i_fwd_rdata), .o_pci_done(i_pci_done),
        .o_pci_abort(i_pci_abort), .o_pci_rdata(i_pci_rdata));
    always #2.5 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        if (o_pci_req && !seen) begin
            npci++;
            cap_addr = o_pci_addr;
        end
        if (o_fwd_req) {cap_fwd, cap_fctl, cap_fwdat} = {o_fwd_addr, o_fwd_write, o_fwd_be, o_fwd_wdata};
        seen = o_pci_req;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One request at a time, next one only after the ack
    task automatic io(input logic w, input logic [15:0] a, input logic [3:0] be,
                      input logic [31:0] wd);
        int n;
        n = 0;
        {i_io_req, i_io_write, i_io_addr, i_io_be, i_io_wdata} = {1'b1, w, a, be, wd};
        @(negedge i_sys_clk);
        i_io_req = 1'b0;
        while (o_io_ack !== 1'b1 && n < 64) begin
            @(negedge i_sys_clk);
            n++;
        end
        if (n == 64) failures++;
        @(negedge i_sys_clk);
    endtask
    task automatic final_report();
        if (failures == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #50000;
        failures++;
        final_report();
    end
    initial begin
        {i_io_req, i_io_write, i_io_addr, i_io_be, i_io_wdata} = '0;
        {i_sys_clk, i_rst_n, abort_en, wait_n, exp_w} = '0;
        repeat (20) @(negedge i_sys_clk);
        i_rst_n = 1'b1;
        chk(o_target_select, TARGET_SELECT_RESET);
        io(1'b1, IO_PORT_TARGET_SELECT, 4'hf, 32'hfff3_5aff);
        chk(o_target_select, 32'h80f3_5afc);
        io(1'b0, IO_PORT_TARGET_SELECT, 4'hf, 32'h0);
        chk(o_io_rdata, 32'h80f3_5afc);
        io(1'b0, IO_PORT_DATA_WINDOW, 4'hf, 32'h0);
        chk(cap_addr, 32'h00f3_5afd);
        chk(o_io_rdata, exp_w);
        io(1'b1, IO_PORT_TARGET_SELECT, 4'h3, 32'hc3c3_5a5a);
        chk({16'h0, cap_fwd}, 32'h0cf8);
        chk({27'h0, cap_fctl}, {27'h0, 1'b1, 4'h3});
        chk(cap_fwdat, 32'hc3c3_5a5a);
        chk(o_target_select, 32'h80f3_5afc);
        io(1'b1, 16'h0070, 4'h1, 32'h0000_0080);
        chk({16'h0, cap_fwd}, 32'h0070);
        chk(o_io_rdata, 32'h1357_9bdf);
        io(1'b1, IO_PORT_TARGET_SELECT, 4'hf, 32'h0000_1800);
        io(1'b0, IO_PORT_DATA_WINDOW, 4'hf, 32'h0);
        chk(o_io_rdata, 32'h1357_9bdf);
        chk({16'h0, cap_fwd}, 32'h0cfc);
        for (int i = 0; i < 4; i++) begin
            wait_n = 4'(i * 5);
            sel = {1'b1, 7'h0, 8'h00, devs[i], 3'(i + 2), 6'(i * 13 + 1), 2'b00};
            d = 32'hc3a5_0f69 ^ {4{8'(i * 17)}};
            m = {{8{bes[i][3]}}, {8{bes[i][2]}}, {8{bes[i][1]}}, {8{bes[i][0]}}};
            exp_w = (exp_w & ~m) | (d & m);
            io(1'b1, IO_PORT_TARGET_SELECT, 4'hf, sel);
            io(1'b1, IO_PORT_DATA_WINDOW, bes[i], d);
            chk(cap_addr, (32'h1 << (11 + devs[i])) | {21'h0, sel[10:2], 2'b00});
            io(1'b0, IO_PORT_DATA_WINDOW, 4'hf, 32'h0);
            chk(o_io_rdata, exp_w);
        end
        n0 = npci;
        io(1'b0, IO_PORT_DATA_WINDOW, BE_NONE, 32'h0);
        chk(o_io_rdata, NO_BYTE_READ_DATA);
        io(1'b1, IO_PORT_TARGET_SELECT, 4'hf, 32'h8000_a800);
        io(1'b0, IO_PORT_DATA_WINDOW, 4'hf, 32'h0);
        chk(o_io_rdata, ABORT_READ_DATA);
        chk(32'(npci), 32'(n0));
        abort_en = 1'b1;
        io(1'b1, IO_PORT_TARGET_SELECT, 4'hf, 32'h8000_1808);
        io(1'b0, IO_PORT_DATA_WINDOW, 4'hf, 32'h0);
        chk(o_io_rdata, ABORT_READ_DATA);
        final_report();
    end
endmodule
`default_nettype wire
